// ---- logic/hbap_top.sv ----
`timescale 1ns/1ps
// How it works
// - After reset, detect separate strobes or direction-strobe.
// - Separate strobes default; style kept until reset.
// - addr_bit_zero activity selects non-multiplexed; else multiplexed.
// - Chip select with read freezes both modes.
// - Registers direct, no waits; RAM via pointer.
// - Pointer auto-increments or stays for random access.
// - RAM reads are prefetched into data register.
// - Pointer-low write fetches when read direction set; plain data read doesn't.
// - Data write held, then stored at pointer.
// - New read pointer prefetches first byte immediately.
// - Reading status_reg_a clears it via read pulse.
// - Fast mode samples address, select on first delay.
// - Effective read delayed on fall, not on rise.
// - Read data path uses live address and strobe.
// - Sampled signals drive clear and prefetch pulses.
// - Delays about 15 ns, then 10 ns more.
// - fast_read_timing_sel selects fast reads; writes normal.
// - Same scheme for direction-plus-data-strobe hosts.
module hbap_top
    import hbap_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire hbap_bus_t host,
    input wire logic [7:0] status_set,
    input wire logic [7:0] next_node_id,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ds_mode,
    output logic nonmux_mode,
    output logic modes_frozen,
    output logic fast_read_timing_sel
);
    // ----------------------------------------
    // Interface style detection
    // ----------------------------------------
    logic frozen_r, frozen_nxt, ds_mode_r, ds_mode_nxt, nonmux_r, nonmux_nxt;
    logic rd_pin, wr_pin, cs_pin, strobe_any;

    assign rd_pin = ~host.read_strobe_low;
    assign wr_pin = ~host.write_strobe_low;
    assign cs_pin = ~host.chip_select_low;
    assign strobe_any = rd_pin | wr_pin;

    // Both control lines low together only happens on a strobe-plus-direction write
    always_comb begin
        frozen_nxt = frozen_r;
        ds_mode_nxt = ds_mode_r;
        nonmux_nxt = nonmux_r;
        if (!frozen_r) begin
            if (rd_pin && wr_pin) begin
                ds_mode_nxt = 1'b1;
            end
            if (cs_pin && strobe_any && host.reg_addr_lines[0]) begin
                nonmux_nxt = 1'b1;
            end
            if (cs_pin && rd_pin) begin
                frozen_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frozen_r <= 1'b0;
            ds_mode_r <= 1'b0;
            nonmux_r <= 1'b0;
        end else begin
            frozen_r <= frozen_nxt;
            ds_mode_r <= ds_mode_nxt;
            nonmux_r <= nonmux_nxt;
        end
    end

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    logic rd_act, wr_act, live_rd, live_wr, fast;
    logic [2:0] live_addr, alat_r, alat_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;

    // Direction high means read in the strobe-plus-direction style
    assign rd_act = ds_mode_r ? (rd_pin && !wr_pin) : rd_pin;
    assign wr_act = ds_mode_r ? (rd_pin && wr_pin) : wr_pin;
    assign live_addr = nonmux_r ? host.reg_addr_lines : alat_r;
    assign live_rd = rd_act && cs_pin;
    assign live_wr = wr_act && cs_pin;
    assign fast = ctrl_r[CTRL_FAST_BIT];

    // Multiplexed bus carries the register address on the data lines
    always_comb begin
        alat_nxt = host.addr_latch_en ? host.data_in[2:0] : alat_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alat_r <= 3'h0;
        end else begin
            alat_r <= alat_nxt;
        end
    end

    // ----------------------------------------
    // Delayed read strobes
    // ----------------------------------------
    logic read_delayed_first, read_delayed_second;

    hbap_delay #(.N(RD1_CYC)) u_rd1 (
        .clock(clock),
        .rst(rst),
        .in_low(~rd_act),
        .out_low(read_delayed_first)
    );

    hbap_delay #(.N(RD2_CYC)) u_rd2 (
        .clock(clock),
        .rst(rst),
        .in_low(read_delayed_first),
        .out_low(read_delayed_second)
    );

    // ----------------------------------------
    // Sampling and read/write pulse generation
    // ----------------------------------------
    logic rd1_prev_r, real_prev_r, wr_prev_r, samp_cs_r, samp_cs_nxt, real_rd;
    logic rd_end, wr_end;
    logic [2:0] samp_addr_r, samp_addr_nxt, wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;

    assign real_rd = fast ? (!read_delayed_second && samp_cs_r) : live_rd;
    assign rd_end = real_prev_r && !real_rd;
    assign wr_end = wr_prev_r && !live_wr;

    // Fast mode captures on the first delayed edge; normal mode tracks the live lines
    always_comb begin
        samp_addr_nxt = samp_addr_r;
        samp_cs_nxt = samp_cs_r;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (fast) begin
            if (rd1_prev_r && !read_delayed_first) begin
                samp_addr_nxt = live_addr;
                samp_cs_nxt = cs_pin;
            end
        end else if (live_rd) begin
            samp_addr_nxt = live_addr;
            samp_cs_nxt = 1'b1;
        end
        if (live_wr) begin
            wr_addr_nxt = live_addr;
            wr_data_nxt = host.data_in;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd1_prev_r <= 1'b1;
            real_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            samp_cs_r <= 1'b0;
            samp_addr_r <= 3'h0;
            wr_addr_r <= 3'h0;
            wr_data_r <= 8'h00;
        end else begin
            rd1_prev_r <= read_delayed_first;
            real_prev_r <= real_rd;
            wr_prev_r <= live_wr;
            samp_cs_r <= samp_cs_nxt;
            samp_addr_r <= samp_addr_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // ----------------------------------------
    // Registers, pointer and buffer sequencing
    // ----------------------------------------
    logic [7:0] stat_r, stat_nxt, data_r, data_nxt, ram_rdata;
    logic [10:0] ptr_r, ptr_nxt;
    logic ptr_rd_r, ptr_rd_nxt, ptr_inc_r, ptr_inc_nxt;
    hbap_state_t state_r, state_nxt;
    hbap_ram_req_t ram_req;

    always_comb begin
        stat_nxt = stat_r;
        ctrl_nxt = ctrl_r;
        data_nxt = data_r;
        ptr_nxt = ptr_r;
        ptr_rd_nxt = ptr_rd_r;
        ptr_inc_nxt = ptr_inc_r;
        state_nxt = state_r;
        ram_req = '{we: 1'b0, addr: ptr_r, wdata: data_r};
        unique case (state_r)
            ST_IDLE: begin
            end
            ST_FETCH: begin
                state_nxt = ST_LOAD;
            end
            ST_LOAD: begin
                data_nxt = ram_rdata;
                state_nxt = ST_IDLE;
            end
            ST_STORE: begin
                ram_req.we = 1'b1;
                if (ptr_inc_r) begin
                    ptr_nxt = ptr_r + 11'h001;
                end
                state_nxt = ST_IDLE;
            end
        endcase
        if (rd_end && samp_addr_r == ADR_STAT) begin
            stat_nxt = 8'h00;
        end
        // Auto-increment reads with read direction set advance and prefetch; a plain data read changes nothing
        if (rd_end && samp_addr_r == ADR_DATA && ptr_rd_r && ptr_inc_r) begin
            ptr_nxt = ptr_r + 11'h001;
            state_nxt = ST_FETCH;
        end
        if (wr_end) begin
            unique case (wr_addr_r)
                ADR_CTRL: ctrl_nxt = wr_data_r;
                ADR_PTR_HI: begin
                    ptr_rd_nxt = wr_data_r[PTR_RD_BIT];
                    ptr_inc_nxt = wr_data_r[PTR_INC_BIT];
                    ptr_nxt = {wr_data_r[2:0], ptr_r[7:0]};
                end
                ADR_PTR_LO: begin
                    ptr_nxt = {ptr_r[10:8], wr_data_r};
                    if (ptr_rd_r) begin
                        state_nxt = ST_FETCH;
                    end
                end
                ADR_DATA: begin
                    data_nxt = wr_data_r;
                    state_nxt = ST_STORE;
                end
                default: begin
                end
            endcase
        end
        // Hardware events win over a clear in the same cycle
        stat_nxt = stat_nxt | status_set;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stat_r <= STAT_RST;
            ctrl_r <= CTRL_RST;
            data_r <= 8'h00;
            ptr_r <= PTR_RST;
            ptr_rd_r <= 1'b0;
            ptr_inc_r <= 1'b0;
            state_r <= ST_IDLE;
        end else begin
            stat_r <= stat_nxt;
            ctrl_r <= ctrl_nxt;
            data_r <= data_nxt;
            ptr_r <= ptr_nxt;
            ptr_rd_r <= ptr_rd_nxt;
            ptr_inc_r <= ptr_inc_nxt;
            state_r <= state_nxt;
        end
    end

    hbap_ram #(.AW(RAM_AW), .DW(RAM_DW)) u_ram (
        .clock(clock),
        .rst(rst),
        .we(ram_req.we),
        .addr(ram_req.addr),
        .wdata(ram_req.wdata),
        .rdata(ram_rdata)
    );

    // ----------------------------------------
    // Read data path
    // ----------------------------------------
    // Live lines keep access time short; delayed copies only feed the pulses
    always_comb begin
        unique case (live_addr)
            ADR_STAT: data_out = stat_r;
            ADR_CTRL: data_out = ctrl_r;
            ADR_PTR_HI: data_out = {ptr_rd_r, ptr_inc_r, 3'h0, ptr_r[10:8]};
            ADR_PTR_LO: data_out = ptr_r[7:0];
            ADR_DATA: data_out = data_r;
            ADR_NEXT_ID: data_out = next_node_id;
            default: data_out = 8'h00;
        endcase
    end

    assign data_oe = live_rd;
    assign ds_mode = ds_mode_r;
    assign nonmux_mode = nonmux_r;
    assign modes_frozen = frozen_r;
    assign fast_read_timing_sel = fast;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_ptr_load;
        wr_end && wr_addr_r == ADR_PTR_LO && ptr_rd_r && !rd_end;
    endsequence
    sequence s_fetch_done;
        state_r == ST_FETCH ##1 state_r == ST_LOAD ##1 data_r == $past(ram_rdata);
    endsequence

    a_freeze_cause: assert property ($rose(frozen_r) |-> $past(cs_pin && rd_pin))
        else $error("freeze without select and read");
    a_modes_stuck: assert property (frozen_r |=> $stable(ds_mode_r) && $stable(nonmux_r))
        else $error("mode changed after freeze");
    a_ds_detect: assert property (!frozen_r && rd_pin && wr_pin |=> ds_mode_r)
        else $error("strobe style not detected");
    a_nonmux_detect: assert property (
        !frozen_r && cs_pin && strobe_any && host.reg_addr_lines[0] |=> nonmux_r)
        else $error("addressing style not detected");
    a_stat_clear: assert property (
        rd_end && samp_addr_r == ADR_STAT && status_set == 8'h00 |=> stat_r == 8'h00)
        else $error("status not cleared by read");
    a_ptr_prefetch: assert property (s_ptr_load |=> s_fetch_done)
        else $error("pointer load did not prefetch");
    a_data_store: assert property (
        wr_end && wr_addr_r == ADR_DATA && !rd_end
        |=> ram_req.we && ram_req.wdata == $past(wr_data_r) && ram_req.addr == ptr_r)
        else $error("data write not stored");
    a_plain_read: assert property (
        rd_end && samp_addr_r == ADR_DATA && !ptr_inc_r && !wr_end && state_r == ST_IDLE
        |=> $stable(data_r) && state_r == ST_IDLE)
        else $error("plain data read fetched");
    a_fast_stable: assert property (
        fast && real_rd && $past(real_rd) |-> $stable(samp_addr_r))
        else $error("sampled address moved during read");
endmodule // hbap_top

// ---- logic/hbap_pkg.sv ----
package hbap_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RD1_DELAY_NS = 15;
    localparam int RD2_DELAY_NS = 10;
    // Least delays, rounded up to whole cycles
    localparam int RD1_CYC = (RD1_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD2_CYC = (RD2_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Register map and fields
    // ----------------------------------------
    localparam int RAM_AW = 11;
    localparam int RAM_DW = 8;
    localparam logic [2:0] ADR_STAT = 3'h0;
    localparam logic [2:0] ADR_CTRL = 3'h1;
    localparam logic [2:0] ADR_PTR_HI = 3'h2;
    localparam logic [2:0] ADR_PTR_LO = 3'h3;
    localparam logic [2:0] ADR_DATA = 3'h4;
    localparam logic [2:0] ADR_NEXT_ID = 3'h5;
    localparam int CTRL_FAST_BIT = 0;
    localparam int PTR_RD_BIT = 7;
    localparam int PTR_INC_BIT = 6;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [10:0] PTR_RST = 11'h000;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic chip_select_low;
        logic read_strobe_low;   // Also data_strobe_low in strobe-plus-direction style
        logic write_strobe_low;  // Also bus_direction (high = read) in that style
        logic addr_latch_en;
        logic [2:0] reg_addr_lines;
        logic [7:0] data_in;
    } hbap_bus_t;

    typedef struct packed {
        logic we;
        logic [RAM_AW-1:0] addr;
        logic [RAM_DW-1:0] wdata;
    } hbap_ram_req_t;

    typedef enum {ST_IDLE, ST_FETCH, ST_LOAD, ST_STORE} hbap_state_t;

endpackage

// ---- logic/hbap_delay.sv ----
`timescale 1ns/1ps
// Active-low strobe delay: assertion lags by N cycles, release passes at once
module hbap_delay #(
    parameter int N = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_low,
    output logic out_low
);
    logic [N-1:0] sh_r;
    logic [N-1:0] sh_nxt;

    // ----------------------------------------
    // Shift chain
    // ----------------------------------------
    always_comb begin
        sh_nxt = in_low ? '0 : ((sh_r << 1) | N'(1));
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // Rising edge is not delayed so the effective read never outlives the host one
    assign out_low = in_low | ~sh_r[N-1];
endmodule // hbap_delay

// ---- logic/hbap_ram.sv ----
`timescale 1ns/1ps
// Packet buffer with registered read data
module hbap_ram #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_nxt;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_comb begin
        rdata_nxt = mem[addr];
    end

    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule // hbap_ram

// ---- sim/hbap_host_model.sv ----
`timescale 1ns/1ps
// Host bus master: drives the port pins the way a small controller would
module hbap_host_model
    import hbap_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] data_out,
    output hbap_bus_t bus
);
    logic ds_style;  // Direction plus data strobe when set
    logic mux_style; // Address rides on data_in under addr_latch_en
    logic [2:0] alt_addr;
    int alt_after;

    // ----------------------------------------
    // Idle state
    // ----------------------------------------
    // Start with every strobe inactive and no address phase
    initial begin
        ds_style = 1'b0;
        mux_style = 1'b0;
        alt_addr = 3'h0;
        alt_after = 99;
        bus = '{chip_select_low: 1'b1, read_strobe_low: 1'b1, write_strobe_low: 1'b1,
                addr_latch_en: 1'b0, reg_addr_lines: 3'h0, data_in: 8'h00};
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Write to some other memory with the port deselected
    task automatic ext_write();
        @(posedge clock);
        bus.data_in <= 8'h5a;
        bus.write_strobe_low <= 1'b0;
        if (ds_style) begin
            bus.read_strobe_low <= 1'b0;
        end
        repeat (2) @(posedge clock);
        bus.write_strobe_low <= 1'b1;
        bus.read_strobe_low <= 1'b1;
        bus.data_in <= 8'ha5; // Released lines never keep the last byte
        repeat (5) @(posedge clock);
    endtask

    // One access held for n edges; the answer is taken at the last of them.
    // alt_after lets the address move mid-strobe like a fast core does.
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          input int n, output logic [7:0] q);
        if (mux_style) begin
            @(posedge clock);
            bus.addr_latch_en <= 1'b1;
            bus.data_in <= {5'h00, a};
            @(posedge clock);
            bus.addr_latch_en <= 1'b0;
        end else begin
            @(posedge clock);
        end
        bus.chip_select_low <= 1'b0;
        bus.reg_addr_lines <= mux_style ? 3'h0 : a;
        bus.data_in <= wr ? d : ~d;
        bus.write_strobe_low <= !wr;
        bus.read_strobe_low <= ds_style ? 1'b0 : wr;
        for (int i = 1; i <= n; i++) begin
            @(posedge clock);
            if (i == alt_after) begin
                bus.reg_addr_lines <= alt_addr;
            end
        end
        q = data_out;
        bus.chip_select_low <= 1'b1;
        bus.read_strobe_low <= 1'b1;
        bus.write_strobe_low <= 1'b1;
        bus.data_in <= ~bus.data_in;
        bus.reg_addr_lines <= ~bus.reg_addr_lines; // Address moves as the strobe lets go
        repeat (5) @(posedge clock); // Gap covers store and prefetch
    endtask

    // Outside write first, then odd write and odd read
    task automatic detect_seq();
        logic [7:0] q;
        ext_write();
        access(1'b1, 3'h1, 8'h00, 1, q);
        access(1'b0, 3'h1, 8'h00, 1, q);
    endtask
endmodule // hbap_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import hbap_pkg::*; ;
    logic clock;
    logic rst;
    hbap_bus_t bus_m;
    hbap_bus_t host;
    logic [7:0] status_set;
    logic [7:0] next_node_id;
    logic [7:0] data_out;
    logic data_oe;
    logic ds_mode;
    logic nonmux_mode;
    logic modes_frozen;
    logic fast_read_timing_sel;
    logic [7:0] q;
    int n_fail;
    int comparisons;

    // ----------------------------------------
    // Clock, wire and instances
    // ----------------------------------------
    always #(CLK_PERIOD_NS / 2) clock = ~clock;

    // Shared data wire: the port wins while it drives a read
    always_comb begin
        host = bus_m;
        if (data_oe) begin
            host.data_in = data_out;
        end
    end

    hbap_host_model u_hbap_host_model (.clock(clock), .data_out(data_out), .bus(bus_m));

    hbap_top u_hbap_top (.clock(clock), .rst(rst), .host(host), .status_set(status_set),
        .next_node_id(next_node_id), .data_out(data_out), .data_oe(data_oe),
        .ds_mode(ds_mode), .nonmux_mode(nonmux_mode), .modes_frozen(modes_frozen),
        .fast_read_timing_sel(fast_read_timing_sel));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_hbap_host_model.access(1'b1, a, d, 1, unused);
    endtask

    task automatic rd(input logic [2:0] a, input int n);
        u_hbap_host_model.access(1'b0, a, 8'h00, n, q);
    endtask

    task automatic pulse_status(input logic [7:0] v);
        @(posedge clock);
        status_set <= v;
        @(posedge clock);
        status_set <= 8'h00;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check1(ds_mode, 1'b0, "strobe style default");
        check1(nonmux_mode, 1'b0, "addressing default");
        check1(modes_frozen, 1'b0, "not frozen at reset");
        check1(fast_read_timing_sel, 1'b0, "fast reads off");
        check1(data_oe, 1'b0, "no drive when idle");
    endtask

    // Separate strobes, plain address; a later overlap must not flip the style
    task automatic t_detect();
        u_hbap_host_model.detect_seq();
        check1(ds_mode, 1'b0, "separate strobes kept");
        check1(nonmux_mode, 1'b1, "odd access seen");
        check1(modes_frozen, 1'b1, "frozen after read");
        u_hbap_host_model.ds_style = 1'b1;
        u_hbap_host_model.ext_write();
        u_hbap_host_model.ds_style = 1'b0;
        check1(ds_mode, 1'b0, "style held once decided");
    endtask

    // Pointer crosses from 0x1ff to 0x200 while auto-incrementing
    task automatic t_ram();
        logic [7:0] exp [3] = '{8'ha5, 8'h5a, 8'hc3};
        wr(ADR_PTR_HI, 8'h41);
        wr(ADR_PTR_LO, 8'hfe);
        foreach (exp[i]) wr(ADR_DATA, exp[i]);
        wr(ADR_PTR_HI, 8'hc1);
        wr(ADR_PTR_LO, 8'hfe);
        foreach (exp[i]) begin
            rd(ADR_DATA, 1);
            check8(q, exp[i], "auto-increment read");
        end
        wr(ADR_PTR_HI, 8'h81);
        wr(ADR_PTR_LO, 8'hff);
        repeat (2) begin
            rd(ADR_DATA, 1);
            check8(q, 8'h5a, "fixed pointer read");
        end
        // Write direction: a fetch on read would show the byte at the advanced pointer
        wr(ADR_PTR_HI, 8'h41);
        wr(ADR_DATA, 8'h77);
        repeat (2) begin
            rd(ADR_DATA, 1);
            check8(q, 8'h77, "data read loads nothing");
        end
    endtask

    task automatic t_status();
        pulse_status(8'h24);
        rd(ADR_STAT, 1);
        check8(q, 8'h24, "status read");
        rd(ADR_STAT, 1);
        check8(q, 8'h00, "status cleared by read");
        rd(ADR_NEXT_ID, 1);
        check8(q, 8'h3c, "next node id");
        rd(3'h6, 1);
        check8(q, 8'h00, "unmapped read");
    endtask

    // Address moves from status to control mid-strobe; only the sampled
    // address of fast mode makes that read clear the status
    task automatic t_fast();
        pulse_status(8'h81);
        u_hbap_host_model.alt_addr = ADR_CTRL;
        u_hbap_host_model.alt_after = 3;
        rd(ADR_STAT, 6);
        check8(q, 8'h00, "live address drives data");
        u_hbap_host_model.alt_after = 99;
        rd(ADR_STAT, 1);
        check8(q, 8'h81, "normal read kept status");
        wr(ADR_CTRL, 8'h01);
        check1(fast_read_timing_sel, 1'b1, "fast reads on");
        pulse_status(8'h42);
        u_hbap_host_model.alt_after = 3;
        rd(ADR_STAT, 6);
        check8(q, 8'h01, "live address in fast mode");
        u_hbap_host_model.alt_after = 99;
        rd(ADR_STAT, 6);
        check8(q, 8'h00, "sampled address cleared status");
    endtask

    // Fresh reset, direction plus data strobe on a multiplexed bus
    task automatic t_ds_mux();
        do_reset();
        u_hbap_host_model.ds_style = 1'b1;
        u_hbap_host_model.mux_style = 1'b1;
        u_hbap_host_model.detect_seq();
        check1(ds_mode, 1'b1, "direction style detected");
        check1(nonmux_mode, 1'b0, "multiplexed kept");
        check1(modes_frozen, 1'b1, "frozen again");
        rd(ADR_NEXT_ID, 1);
        check8(q, 8'h3c, "direction style read");
        wr(ADR_CTRL, 8'h01);
        check1(fast_read_timing_sel, 1'b1, "direction style write");
        pulse_status(8'h10);
        rd(ADR_STAT, 6);
        check8(q, 8'h10, "fast read in direction style");
        rd(ADR_STAT, 6);
        check8(q, 8'h00, "fast clear in direction style");
    endtask

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        status_set = 8'h00;
        next_node_id = 8'h3c;
        n_fail = 0;
        comparisons = 0;
        do_reset();
        t_reset();
        t_detect();
        t_ram();
        t_status();
        t_fast();
        t_ds_mux();
        give_verdict();
    end

    // A stuck sequence costs a mismatch rather than an endless run
    initial begin
        for (int i = 0; i < 60000; i++) begin
            @(posedge clock);
        end
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule // tb_top
